// [cmc_mau_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module cmc_mau_ctrl
  import cmc_pkg::*;
#(
  parameter int XCOL_N = XCOL_CYC,
  parameter int JAB_ACT_N = JAB_ACT_CYC,
  parameter int JAB_RST_N = JAB_RST_CYC,
  parameter int JAB_EXIT_N = JAB_EXIT_CYC
) (
  input wire logic core_clk, // 10 MHz core clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic tx_squelch_level, // Transmit input beyond squelch threshold.
  input wire logic tx_data, // Transmit data from the manchester_converter.
  input wire cmc_cable_s cable_receive_input, // Cable comparators.
  input wire cmc_hbsel_s heartbeat_select_input, // Decoded three-level select.
  output logic cable_transmit_output, // Data toward the cable driver.
  output logic cable_transmit_enable, // Cable driver active.
  output logic rx_data_out, // Receive data toward the station.
  output logic rx_enable, // Receive driver active.
  output logic collision_indication_pair, // Collision signal, 5 MHz burst.
  output logic collision_indication_enable // Collision driver active.
);

  logic [2:0] tx_s;
  logic [2:0] rx_s;
  logic [1:0] hb_s;

  // All pin inputs cross in through two flops.
  cmc_sync #(.W(8)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .d_in({tx_squelch_level, tx_data, 1'b0, cable_receive_input, heartbeat_select_input}),
    .q_out({tx_s, rx_s, hb_s})
  );

  logic sq_lvl, txd, carr, coll, rxd;
  cmc_hbmode_e mode;
  assign sq_lvl = tx_s[2];
  assign txd = tx_s[1];
  assign carr = rx_s[2] | rx_s[1];
  assign coll = rx_s[1];
  assign rxd = rx_s[0];

  // Three-level decode; neither wire means the middle or floating level.
  always_comb begin
    if (hb_s[1]) mode = HB_ON;
    else if (hb_s[0]) mode = HB_OFF;
    else mode = HB_TEST;
  end

  // Transmit state group.
  logic sq_open_ff, nxt_sq_open_ff;
  logic [SC_W-1:0] sq_cnt_ff, nxt_sq_cnt_ff;
  logic [SC_W-1:0] tx_hi_ff, nxt_tx_hi_ff;
  logic [SC_W-1:0] tx_rej_ff, nxt_tx_rej_ff;
  logic tx_end;

  always_comb begin
    nxt_sq_open_ff = sq_open_ff;
    nxt_sq_cnt_ff = sq_cnt_ff;
    nxt_tx_hi_ff = tx_hi_ff;
    nxt_tx_rej_ff = tx_rej_ff;
    tx_end = 1'b0;
    if (tx_rej_ff != '0) begin
      nxt_tx_rej_ff = tx_rej_ff - 1'b1;
      nxt_sq_cnt_ff = '0;
    end else if (!sq_open_ff) begin
      // Pulse width is measured in whole cycles, so 17 ns needs one sample.
      if (sq_lvl) nxt_sq_cnt_ff = sq_cnt_ff + 1'b1;
      else nxt_sq_cnt_ff = '0;
      if (sq_lvl && (sq_cnt_ff + 1'b1 >= SC_W'(SQ_ON_CYC))) begin
        nxt_sq_open_ff = 1'b1;
        nxt_tx_hi_ff = '0;
      end
    end else begin
      nxt_tx_hi_ff = txd ? tx_hi_ff + 1'b1 : '0;
      // High beyond 175 ns ends the packet; the third high sample in a row ends it, past the 170 ns typical.
      if (!sq_lvl || (txd && tx_hi_ff >= SC_W'(IDL_CYC))) begin
        nxt_sq_open_ff = 1'b0;
        nxt_tx_rej_ff = SC_W'(TX_REJ_CYC);
        nxt_sq_cnt_ff = '0;
        tx_end = 1'b1;
      end
    end
    if (srst) begin
      nxt_sq_open_ff = 1'b0;
      nxt_sq_cnt_ff = '0;
      nxt_tx_hi_ff = '0;
      nxt_tx_rej_ff = '0;
    end else if (!ce) begin
      nxt_sq_open_ff = sq_open_ff;
      nxt_sq_cnt_ff = sq_cnt_ff;
      nxt_tx_hi_ff = tx_hi_ff;
      nxt_tx_rej_ff = tx_rej_ff;
      tx_end = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    sq_open_ff <= nxt_sq_open_ff;
    sq_cnt_ff <= nxt_sq_cnt_ff;
    tx_hi_ff <= nxt_tx_hi_ff;
    tx_rej_ff <= nxt_tx_rej_ff;
  end

  // Jabber and heartbeat group.
  logic jab_ff, nxt_jab_ff;
  logic [CNT_W-1:0] jab_cnt_ff, nxt_jab_cnt_ff;
  logic [CNT_W-1:0] exit_cnt_ff, nxt_exit_cnt_ff;
  logic hb_act_ff, nxt_hb_act_ff;
  logic [SC_W:0] hb_cnt_ff, nxt_hb_cnt_ff;
  logic hb_wait_ff, nxt_hb_wait_ff;
  logic jab_allowed;
  assign jab_allowed = (mode != HB_TEST) && (exit_cnt_ff == '0);

  always_comb begin
    nxt_jab_ff = jab_ff;
    nxt_jab_cnt_ff = jab_cnt_ff;
    nxt_exit_cnt_ff = exit_cnt_ff;
    nxt_hb_act_ff = hb_act_ff;
    nxt_hb_cnt_ff = hb_cnt_ff;
    nxt_hb_wait_ff = hb_wait_ff;
    // Test mode reloads the exit timer so jabber waits 0.5 s after leaving it.
    if (mode == HB_TEST) nxt_exit_cnt_ff = CNT_W'(JAB_EXIT_N);
    else if (exit_cnt_ff != '0) nxt_exit_cnt_ff = exit_cnt_ff - 1'b1;
    if (jab_ff) begin
      // Reset time-out runs regardless of the transmit input.
      if (jab_cnt_ff + 1'b1 >= CNT_W'(JAB_RST_N)) begin
        nxt_jab_ff = 1'b0;
        nxt_jab_cnt_ff = '0;
      end else nxt_jab_cnt_ff = jab_cnt_ff + 1'b1;
    end else if (sq_open_ff && jab_allowed) begin
      if (jab_cnt_ff + 1'b1 >= CNT_W'(JAB_ACT_N)) begin
        nxt_jab_ff = 1'b1;
        nxt_jab_cnt_ff = '0;
        nxt_hb_wait_ff = 1'b0;
        nxt_hb_act_ff = 1'b0;
      end else nxt_jab_cnt_ff = jab_cnt_ff + 1'b1;
    end else nxt_jab_cnt_ff = '0;
    // Heartbeat: wait 1.1 us after transmit end, then 1.0 us burst.
    if (tx_end && mode == HB_ON && !jab_ff) begin
      nxt_hb_wait_ff = 1'b1;
      nxt_hb_cnt_ff = '0;
    end else if (hb_wait_ff) begin
      if (mode != HB_ON || jab_ff) nxt_hb_wait_ff = 1'b0;
      else if (hb_cnt_ff + 1'b1 >= (SC_W+1)'(HB_DLY_CYC)) begin
        nxt_hb_wait_ff = 1'b0;
        nxt_hb_act_ff = 1'b1;
        nxt_hb_cnt_ff = '0;
      end else nxt_hb_cnt_ff = hb_cnt_ff + 1'b1;
    end else if (hb_act_ff) begin
      if (hb_cnt_ff + 1'b1 >= (SC_W+1)'(HB_W_CYC) || jab_ff) begin
        nxt_hb_act_ff = 1'b0;
        nxt_hb_cnt_ff = '0;
      end else nxt_hb_cnt_ff = hb_cnt_ff + 1'b1;
    end
    if (srst) begin
      nxt_jab_ff = 1'b0;
      nxt_jab_cnt_ff = '0;
      nxt_exit_cnt_ff = '0;
      nxt_hb_act_ff = 1'b0;
      nxt_hb_cnt_ff = '0;
      nxt_hb_wait_ff = 1'b0;
    end else if (!ce) begin
      nxt_jab_ff = jab_ff;
      nxt_jab_cnt_ff = jab_cnt_ff;
      nxt_exit_cnt_ff = exit_cnt_ff;
      nxt_hb_act_ff = hb_act_ff;
      nxt_hb_cnt_ff = hb_cnt_ff;
      nxt_hb_wait_ff = hb_wait_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    jab_ff <= nxt_jab_ff;
    jab_cnt_ff <= nxt_jab_cnt_ff;
    exit_cnt_ff <= nxt_exit_cnt_ff;
    hb_act_ff <= nxt_hb_act_ff;
    hb_cnt_ff <= nxt_hb_cnt_ff;
    hb_wait_ff <= nxt_hb_wait_ff;
  end

  // Receive group.
  logic rx_on_ff, nxt_rx_on_ff;
  logic [SC_W-1:0] rx_hi_ff, nxt_rx_hi_ff;
  logic [SC_W-1:0] rx_rej_ff, nxt_rx_rej_ff;
  logic idl_ff, nxt_idl_ff;
  logic [CNT_W-1:0] xcol_ff, nxt_xcol_ff;
  logic xcol_off;
  assign xcol_off = (xcol_ff >= CNT_W'(XCOL_N));

  always_comb begin
    nxt_rx_on_ff = rx_on_ff;
    nxt_rx_hi_ff = rx_hi_ff;
    nxt_rx_rej_ff = rx_rej_ff;
    nxt_idl_ff = 1'b0;
    // Timer counts only unbroken collision and saturates at the limit.
    if (!coll) nxt_xcol_ff = '0;
    else if (!xcol_off) nxt_xcol_ff = xcol_ff + 1'b1;
    else nxt_xcol_ff = xcol_ff;
    if (rx_rej_ff != '0) begin
      nxt_rx_rej_ff = rx_rej_ff - 1'b1;
    end else if (!rx_on_ff) begin
      // Enable within two sync cycles plus one, well inside five bit times.
      if (carr) begin
        nxt_rx_on_ff = 1'b1;
        nxt_rx_hi_ff = '0;
      end
    end else begin
      nxt_rx_hi_ff = rxd ? rx_hi_ff + 1'b1 : '0;
      if (!carr || (rxd && rx_hi_ff >= SC_W'(IDL_CYC))) begin
        nxt_rx_on_ff = 1'b0;
        nxt_idl_ff = 1'b1;
        nxt_rx_rej_ff = SC_W'(RX_REJ_CYC);
      end
    end
    if (srst) begin
      nxt_rx_on_ff = 1'b0;
      nxt_rx_hi_ff = '0;
      nxt_rx_rej_ff = '0;
      nxt_idl_ff = 1'b0;
      nxt_xcol_ff = '0;
    end else if (!ce) begin
      nxt_rx_on_ff = rx_on_ff;
      nxt_rx_hi_ff = rx_hi_ff;
      nxt_rx_rej_ff = rx_rej_ff;
      nxt_idl_ff = idl_ff;
      nxt_xcol_ff = xcol_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    rx_on_ff <= nxt_rx_on_ff;
    rx_hi_ff <= nxt_rx_hi_ff;
    rx_rej_ff <= nxt_rx_rej_ff;
    idl_ff <= nxt_idl_ff;
    xcol_ff <= nxt_xcol_ff;
  end

  // Output group; every pin is a flop, so outputs trail state by one cycle.
  logic tx_out_ff, nxt_tx_out_ff, tx_en_ff, nxt_tx_en_ff;
  logic rxo_ff, nxt_rxo_ff, rxe_ff, nxt_rxe_ff;
  logic cd_ff, nxt_cd_ff, cde_ff, nxt_cde_ff;
  logic osc_ff, nxt_osc_ff;
  logic cd_src;
  assign cd_src = coll || jab_ff || hb_act_ff;

  always_comb begin
    nxt_osc_ff = ~osc_ff;
    // Idle cable level is data high, which draws no current.
    nxt_tx_en_ff = sq_open_ff && !jab_ff;
    nxt_tx_out_ff = nxt_tx_en_ff ? txd : 1'b1;
    // The appended idle pulse is one cycle of high with the driver on.
    nxt_rxe_ff = (rx_on_ff && !xcol_off) || idl_ff;
    nxt_rxo_ff = idl_ff ? 1'b1 : (nxt_rxe_ff && rxd);
    // Oscillator toggle at core rate gives a 5 MHz square; the true 10 MHz needs a faster source.
    nxt_cde_ff = cd_src;
    nxt_cd_ff = cd_src && osc_ff;
    if (srst) begin
      nxt_osc_ff = 1'b0;
      nxt_tx_en_ff = 1'b0;
      nxt_tx_out_ff = 1'b1;
      nxt_rxe_ff = 1'b0;
      nxt_rxo_ff = 1'b0;
      nxt_cde_ff = 1'b0;
      nxt_cd_ff = 1'b0;
    end else if (!ce) begin
      nxt_osc_ff = osc_ff;
      nxt_tx_en_ff = tx_en_ff;
      nxt_tx_out_ff = tx_out_ff;
      nxt_rxe_ff = rxe_ff;
      nxt_rxo_ff = rxo_ff;
      nxt_cde_ff = cde_ff;
      nxt_cd_ff = cd_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    osc_ff <= nxt_osc_ff;
    tx_en_ff <= nxt_tx_en_ff;
    tx_out_ff <= nxt_tx_out_ff;
    rxe_ff <= nxt_rxe_ff;
    rxo_ff <= nxt_rxo_ff;
    cde_ff <= nxt_cde_ff;
    cd_ff <= nxt_cd_ff;
  end

  assign cable_transmit_output = tx_out_ff;
  assign cable_transmit_enable = tx_en_ff;
  assign rx_data_out = rxo_ff;
  assign rx_enable = rxe_ff;
  assign collision_indication_pair = cd_ff;
  assign collision_indication_enable = cde_ff;

endmodule // cmc_mau_ctrl
`default_nettype wire

// [cmc_pkg.sv]
package cmc_pkg;

  // Clock rate and derived timing counts.
  localparam int CLK_MHZ = 10;
  localparam int CLK_NS = 100;
  // Transmit squelch turn-on pulse width, in ns (least time, rounds up).
  localparam int SQ_ON_NS = 17;
  localparam int SQ_ON_CYC = (SQ_ON_NS + CLK_NS - 1) / CLK_NS;
  // Idle detection, data high longer than this, in ns (least time).
  localparam int IDL_NS = 175;
  localparam int IDL_CYC = (IDL_NS + CLK_NS - 1) / CLK_NS;
  // Typical transmit idle detection time, in ns; kept for reference.
  localparam int TIDL_TYP_NS = 170;
  // Transmit dribble rejection window, in ns.
  localparam int TX_REJ_NS = 800;
  localparam int TX_REJ_CYC = TX_REJ_NS / CLK_NS;
  // Receive rejection window, in ns.
  localparam int RX_REJ_NS = 1000;
  localparam int RX_REJ_CYC = RX_REJ_NS / CLK_NS;
  // Heartbeat delay and width, in ns.
  localparam int HB_DLY_NS = 1100;
  localparam int HB_DLY_CYC = HB_DLY_NS / CLK_NS;
  localparam int HB_W_NS = 1000;
  localparam int HB_W_CYC = HB_W_NS / CLK_NS;
  // Long timers, in ms; the cycle counts are top-level parameters.
  localparam int XCOL_MS = 250;
  localparam int JAB_ACT_MS = 26;
  localparam int JAB_RST_MS = 420;
  localparam int JAB_EXIT_MS = 500;
  localparam int XCOL_CYC = XCOL_MS * 1000 * CLK_MHZ;
  localparam int JAB_ACT_CYC = JAB_ACT_MS * 1000 * CLK_MHZ;
  localparam int JAB_RST_CYC = JAB_RST_MS * 1000 * CLK_MHZ;
  localparam int JAB_EXIT_CYC = JAB_EXIT_MS * 1000 * CLK_MHZ;
  // Reception start within this many bit times.
  localparam int RX_START_BITS = 5;
  localparam int CNT_W = 24;
  localparam int SC_W = 4;

  // Three-level selection input decoded by the pad into two wires.
  typedef struct packed {
    logic hi;
    logic lo;
  } cmc_hbsel_s;

  // Cable-side comparator outputs from the analog front end.
  typedef struct packed {
    logic carrier;
    logic collision;
    logic data;
  } cmc_cable_s;

  typedef enum logic [1:0] {
    HB_OFF,
    HB_ON,
    HB_TEST
  } cmc_hbmode_e;

endpackage : cmc_pkg

// [cmc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for asynchronous pin levels; first stage feeds only the second.
module cmc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // Core clock.
  input wire logic srst, // Synchronous reset.
  input wire logic ce, // Clock enable.
  input wire logic [W-1:0] d_in, // Asynchronous inputs.
  output logic [W-1:0] q_out // Synchronised outputs.
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_sync_ff;

  // Hold on clock enable low, clear on reset.
  always_comb begin
    nxt_meta_ff = meta_ff;
    nxt_sync_ff = sync_ff;
    if (srst) begin
      nxt_meta_ff = '0;
      nxt_sync_ff = '0;
    end else if (ce) begin
      nxt_meta_ff = d_in;
      nxt_sync_ff = meta_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    meta_ff <= nxt_meta_ff;
    sync_ff <= nxt_sync_ff;
  end

  assign q_out = sync_ff;
endmodule // cmc_sync
`default_nettype wire

// [cmc_mau_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin-level watcher for the control block.
module cmc_mau_ctrl_asserts
  import cmc_pkg::*;
#(
  parameter int XCOL_N = 50,
  parameter int JAB_ACT_N = 40,
  parameter int JAB_RST_N = 60,
  parameter int JAB_EXIT_N = 30
) (
  input wire logic core_clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic tx_squelch_level, // Squelch level.
  input wire cmc_cable_s cable_receive_input, // Cable comparators.
  input wire cmc_hbsel_s heartbeat_select_input, // Mode select.
  input wire logic cable_transmit_output, // Cable data.
  input wire logic cable_transmit_enable, // Cable driver on.
  input wire logic rx_enable, // Receive on.
  input wire logic collision_indication_pair, // Collision signal.
  input wire logic collision_indication_enable // Collision on.
);
  logic [7:0] col_ff, nxt_col, txr_ff, nxt_txr, age_ff, nxt_age;

  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // Run lengths saturate, so a wrap never rearms a check falsely.
  always_comb begin
    nxt_col = cable_receive_input.collision ? inc(col_ff) : 8'h00;
    nxt_txr = cable_transmit_enable ? inc(txr_ff) : 8'h00;
    nxt_age = (heartbeat_select_input == 2'b00) ? 8'h00 : inc(age_ff);
  end

  // Counters register their next values, clearing on reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      col_ff <= 8'h00;
      txr_ff <= 8'h00;
      age_ff <= 8'h00;
    end else begin
      col_ff <= nxt_col;
      txr_ff <= nxt_txr;
      age_ff <= nxt_age;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  tx_idle_out_a: assert property (!cable_transmit_enable |-> cable_transmit_output)
    else $error("cable output active while squelched");
  tx_sq_close_a: assert property (!tx_squelch_level [*6] |-> !cable_transmit_enable)
    else $error("squelch open without level");
  cd_quiet_a: assert property (!collision_indication_enable |-> !collision_indication_pair)
    else $error("collision pair active while idle");
  cd_toggle_a: assert property (
    collision_indication_enable && $past(collision_indication_enable)
    |-> collision_indication_pair != $past(collision_indication_pair))
    else $error("collision pair not oscillating");
  col_cd_on_a: assert property (col_ff >= 8'd6 |-> collision_indication_enable)
    else $error("collision not indicated");
  col_rx_on_a: assert property (col_ff inside {[6:20]} |-> rx_enable)
    else $error("collision did not open receive");
  xcol_off_a: assert property (col_ff >= XCOL_N + 6 |-> !rx_enable)
    else $error("receive open in extended collision");
  rx_reject_a: assert property (
    $fell(rx_enable) && !cable_receive_input.collision |=> !rx_enable [*8])
    else $error("receive reopened inside reject window");
  hb_delay_a: assert property (
    $fell(cable_transmit_enable) && heartbeat_select_input.hi && !collision_indication_enable
    |-> ##[8:14] collision_indication_enable)
    else $error("heartbeat missing");
  jab_limit_a: assert property (
    age_ff > JAB_EXIT_N + 2 * JAB_ACT_N + 10 |-> txr_ff <= JAB_ACT_N + 6)
    else $error("transmit ran past jabber limit");
endmodule // cmc_mau_ctrl_asserts

bind cmc_mau_ctrl cmc_mau_ctrl_asserts #(.XCOL_N(XCOL_N), .JAB_ACT_N(JAB_ACT_N),
  .JAB_RST_N(JAB_RST_N), .JAB_EXIT_N(JAB_EXIT_N)) cmc_mau_ctrl_asserts_i (
  .core_clk(core_clk), .srst(srst), .tx_squelch_level(tx_squelch_level),
  .cable_receive_input(cable_receive_input), .heartbeat_select_input(heartbeat_select_input),
  .cable_transmit_output(cable_transmit_output), .cable_transmit_enable(cable_transmit_enable),
  .rx_enable(rx_enable), .collision_indication_pair(collision_indication_pair),
  .collision_indication_enable(collision_indication_enable));
`default_nettype wire

// [cmc_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Station-side code converter: sends one frame per start request.
module cmc_conv_model (
  input wire logic core_clk, // Clock.
  input wire logic start, // Begin a frame.
  input wire logic [7:0] len, // Frame length in cycles.
  input wire logic drib, // Add a late dribble pulse.
  output logic sq_lvl, // Level beyond squelch threshold.
  output logic tx_d, // Transmit data.
  output logic busy // Frame in progress.
);
  int i;

  // Between frames data toggles, so a leaky squelch shows on the cable.
  initial begin
    sq_lvl = 1'b0;
    tx_d = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (!start) begin
        tx_d <= ~tx_d;
      end else begin
        busy <= 1'b1;
        for (i = 0; i < len; i++) begin
          sq_lvl <= 1'b1;
          tx_d <= i[0];
          @(posedge core_clk);
        end
        tx_d <= 1'b1;
        repeat (5) @(posedge core_clk);
        if (drib) begin
          tx_d <= 1'b0;
          repeat (2) @(posedge core_clk);
          tx_d <= 1'b1;
          @(posedge core_clk);
        end
        sq_lvl <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule // cmc_conv_model
`default_nettype wire

// [cmc_mau_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Drives the block from a converter model and a hand-driven cable.
module cmc_mau_ctrl_tb
  import cmc_pkg::*;
;
  localparam int TXE = 0, RXE = 1, CDE = 2, BSY = 3;
  logic core_clk, srst, ce, sq_lvl, tx_d, start, drib, busy, rx_hold, last;
  logic tx_o, tx_en, rx_do, rx_en, cd, cd_en;
  logic [7:0] len;
  logic [3:0] obs;
  cmc_cable_s cab;
  cmc_hbsel_s hbs;
  int num_errors, samples_checked, n;

  cmc_mau_ctrl #(.XCOL_N(50), .JAB_ACT_N(40), .JAB_RST_N(60), .JAB_EXIT_N(30))
    cmc_mau_ctrl_i (.core_clk(core_clk), .srst(srst), .ce(ce), .tx_squelch_level(sq_lvl),
    .tx_data(tx_d), .cable_receive_input(cab), .heartbeat_select_input(hbs),
    .cable_transmit_output(tx_o), .cable_transmit_enable(tx_en), .rx_data_out(rx_do),
    .rx_enable(rx_en), .collision_indication_pair(cd), .collision_indication_enable(cd_en));
  cmc_conv_model cmc_conv_model_i (.core_clk(core_clk), .start(start), .len(len),
    .drib(drib), .sq_lvl(sq_lvl), .tx_d(tx_d), .busy(busy));

  // Watched flags gathered for the bounded waits.
  assign obs = {busy, cd_en, rx_en, tx_en};

  // Clock at 100 ns.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Cable data toggles unless held at idle.
  always @(posedge core_clk) cab.data <= rx_hold ? 1'b1 : ~cab.data;

  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Counts edges until a flag reaches a value; running out ends the run.
  task automatic wait_for(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v) begin
      if (n == lim) begin
        num_errors++;
        $display("FAIL %0t wait ran out", $time);
        wrap_up();
      end
      n++;
      @(posedge core_clk);
    end
  endtask

  task automatic kick(input logic [7:0] l, input logic d);
    start <= 1'b1;
    len <= l;
    drib <= d;
    cyc(1);
    start <= 1'b0;
  endtask

  task automatic t_tx_hb();
    hbs <= 2'b10;
    kick(8'd20, 1'b0);
    cyc(8);
    chk(tx_en, 1'b1, "squelch stayed shut");
    last = tx_o;
    cyc(1);
    chk(tx_o ^ last, 1'b1, "data not passed");
    wait_for(TXE, 1'b0, 30);
    wait_for(CDE, 1'b1, 20);
    chk(n inside {[8:14]}, 1'b1, "heartbeat delay");
    wait_for(CDE, 1'b0, 20);
    chk(n == HB_W_CYC, 1'b1, "heartbeat width");
  endtask

  task automatic t_drib();
    hbs <= 2'b01;
    kick(8'd12, 1'b1);
    wait_for(TXE, 1'b1, 10);
    wait_for(TXE, 1'b0, 40);
    repeat (20) begin
      cyc(1);
      chk(tx_en, 1'b0, "dribble reopened");
      chk(cd_en, 1'b0, "heartbeat while off");
    end
  endtask

  task automatic t_rx();
    cab.carrier <= 1'b1;
    wait_for(RXE, 1'b1, 6);
    cyc(9);
    // Cable data toggles every cycle, so the station side must toggle too.
    last = rx_do;
    cyc(1);
    chk(rx_do ^ last, 1'b1, "rx data not passed");
    rx_hold <= 1'b1;
    for (n = 0; n < 12 && rx_en === 1'b1; n++) begin
      last = rx_do;
      cyc(1);
    end
    chk(rx_en, 1'b0, "idle did not end");
    chk(last, 1'b1, "no idle pulse");
    rx_hold <= 1'b0;
    repeat (8) begin
      cyc(1);
      chk(rx_en, 1'b0, "reject window open");
    end
    wait_for(RXE, 1'b1, 12);
    cab.carrier <= 1'b0;
    wait_for(RXE, 1'b0, 8);
    cyc(15);
  endtask

  task automatic t_col();
    cab.carrier <= 1'b1;
    cab.collision <= 1'b1;
    cyc(8);
    chk(cd_en, 1'b1, "no collision");
    chk(rx_en, 1'b1, "receive shut");
    cyc(55);
    chk(rx_en, 1'b0, "extended not cut");
    cab.collision <= 1'b0;
    cyc(1);
    cab.collision <= 1'b1;
    wait_for(RXE, 1'b1, 6);
    cyc(40);
    chk(rx_en, 1'b1, "timer not restarted");
    cab.collision <= 1'b0;
    cab.carrier <= 1'b0;
    cyc(20);
  endtask

  task automatic t_jab();
    kick(8'd100, 1'b0);
    cyc(60);
    chk(tx_en, 1'b0, "jabber missing");
    chk(tx_o, 1'b1, "cable not idle");
    chk(cd_en, 1'b1, "jabber not signalled");
    cyc(40);
    chk(cd_en, 1'b1, "jabber ended early");
    wait_for(BSY, 1'b0, 20);
    cyc(20);
    chk(cd_en, 1'b0, "jabber stuck");
  endtask

  task automatic t_test();
    hbs <= 2'b00;
    kick(8'd80, 1'b0);
    cyc(60);
    chk(tx_en, 1'b1, "jabber in test mode");
    wait_for(BSY, 1'b0, 40);
    hbs <= 2'b01;
    // Jabber must stay off while the exit timer still runs.
    kick(8'd60, 1'b0);
    cyc(55);
    chk(cd_en, 1'b0, "jabber during test exit");
    wait_for(BSY, 1'b0, 20);
    cyc(60);
    kick(8'd60, 1'b0);
    cyc(55);
    chk(cd_en, 1'b1, "jabber not back");
    wait_for(BSY, 1'b0, 20);
  endtask

  // Main sequence.
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    drib = 1'b0;
    len = 8'h00;
    rx_hold = 1'b0;
    cab = 3'b000;
    hbs = 2'b10;
    num_errors = 0;
    samples_checked = 0;
    cyc(5);
    srst <= 1'b0;
    cyc(1);
    chk(tx_o, 1'b1, "tx not idle after reset");
    chk(cd, 1'b0, "collision after reset");
    t_tx_hb();
    t_drib();
    t_rx();
    t_col();
    t_jab();
    t_test();
    wrap_up();
  end
endmodule // cmc_mau_ctrl_tb
`default_nettype wire
